// [general_timer_with_pulse_measure_tb_top.sv]
// testbench of the general timer channel
`timescale 1ns/100ps

module general_timer_with_pulse_measure_tb_top;
    import gtimer_pkg::*;
    // ********
    // signals
    // ********
    logic aclk = 1'b0;
    logic aresetn;
    logic ce;
    logic subclk_div_32, other_timer_ovf, timer_event_input_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq, pin_is_count_input, run;
    logic [15:0] half;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int irqs = 0;

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    gtimer dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .subclk_div_32(subclk_div_32),
        .other_timer_ovf(other_timer_ovf), .timer_event_input_pin(timer_event_input_pin),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
        .pin_is_count_input(pin_is_count_input));

    pulse_source src (.aclk(aclk), .aresetn(aresetn), .run(run), .half(half),
        .timer_event_input_pin(timer_event_input_pin), .other_timer_ovf(other_timer_ovf),
        .subclk_div_32(subclk_div_32));

    // interrupt pulse counter and hang watchdog
    always @(posedge aclk)
    begin
        cyc++;
        if (irq === 1'b1)
            irqs++;
        if (cyc == 90000)
        begin
            fails++;
            end_sim();
        end
    end

    // ********
    // helpers
    // ********
    task end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // cycles between two interrupt pulses, 0 when none comes within lim
    task gap(input int lim, output int g);
        int n;
        n = 0;
        g = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            @(posedge aclk);
            #1 n++;
        end
        do
        begin
            @(posedge aclk);
            #1 g++;
        end while (irq !== 1'b1 && g < lim);
        if (irq !== 1'b1)
            g = 0;
    endtask

    task restart(input logic [31:0] m, input logic [31:0] t);
        run <= 1'b0;
        wr(OFS_START, 32'h0);
        wr(OFS_MODE, m);
        wr(OFS_TIMER, t);
        wr(OFS_START, 32'h1);
        run <= 1'b1;
    endtask

    // ********
    // scenarios
    // ********
    task t_reset();
        rd(OFS_MODE);
        chk(32'h0, rv);
        chk({30'h0, RESP_OKAY}, {30'h0, rsp});
        rd(OFS_START);
        chk(32'h0, rv);
        rd(8'h0C);
        chk({30'h0, RESP_SLVERR}, {30'h0, rsp});
        chk(32'h0, rv);
        wr(8'h10, 32'h5);
        chk({30'h0, RESP_SLVERR}, {30'h0, rsp});
    endtask

    task t_clk();
        int g;
        int ex[4];
        ex = '{3, 24, 96, 12};
        for (int c = 0; c < 4; c++)
        begin
            restart({24'h0, c[1:0], 6'h0}, 32'h2);
            gap(200, g);
            chk(ex[c], g);
        end
        chk(32'h0, {31'h0, pin_is_count_input});
    endtask

    task t_reload();
        int g;
        restart(32'h0, 32'h2);
        wr(OFS_TIMER, 32'h5);
        gap(50, g);
        gap(50, g);
        chk(32'h6, g);
        // clock enable low freezes the running timer: no interrupt pulses
        @(posedge aclk);
        ce <= 1'b0;
        @(posedge aclk);
        g = irqs;
        repeat (20) @(posedge aclk);
        chk(g, irqs);
        ce <= 1'b1;
        wr(OFS_START, 32'h0);
        rd(OFS_TIMER);
        g = rv;
        repeat (10) @(posedge aclk);
        rd(OFS_TIMER);
        chk(g, rv);
        wr(OFS_TIMER, 32'h9);
        chk({30'h0, RESP_OKAY}, {30'h0, rsp});
        rd(OFS_TIMER);
        chk(32'h9, rv);
    endtask

    task t_event();
        int g;
        int ex[5];
        ex = '{20, 20, 10, 0, 12};
        half <= 16'h0005;
        for (int i = 0; i < 5; i++)
        begin
            restart(i == 4 ? 32'h11 : {28'h0, i[1:0], MODE_EVENT}, 32'h1);
            gap(60, g);
            chk(ex[i], g);
            if (i < 2)
                chk(i, {31'h0, timer_event_input_pin});
        end
        chk(32'h1, {31'h0, pin_is_count_input});
    endtask

    task t_meas();
        int n0;
        half <= 16'h000A;
        restart(32'h0A, 32'h0);
        n0 = irqs;
        repeat (35) @(posedge aclk);
        chk(32'h2, irqs - n0);
        rd(OFS_TIMER);
        chk(32'h9, rv);
        restart(32'h06, 32'h0);
        repeat (50) @(posedge aclk);
        run <= 1'b0;
        rd(OFS_TIMER);
        chk(32'h13, rv);
        wr(OFS_TIMER, 32'h1234);
        rd(OFS_TIMER);
        chk(32'h13, rv);
        chk(32'h1, {31'h0, pin_is_count_input});
    endtask

    task t_ovf();
        int n0;
        wr(OFS_START, 32'h0);
        wr(OFS_MODE, 32'h02);
        wr(OFS_START, 32'h1);
        n0 = irqs;
        repeat (65540) @(posedge aclk);
        chk(32'h1, irqs - n0);
        rd(OFS_MODE);
        chk(32'h22, rv);
        wr(OFS_MODE, 32'h02);
        rd(OFS_MODE);
        chk(32'h02, rv);
        wr(OFS_MODE, 32'h03);
        rd(OFS_MODE);
        chk(32'h03, rv);
        chk(32'h0, {31'h0, pin_is_count_input});
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        aresetn = 1'b0;
        run = 1'b0;
        ce = 1'b1;
        half = 16'h0005;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_clk();
        t_reload();
        t_event();
        t_meas();
        t_ovf();
        end_sim();
    end
endmodule

// [gtimer.sv]
// one channel of a 16-bit general timer with an AXI4-Lite register slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps

// Function
// - mode register bits 1:0 pick timer, event counter or measurement mode
// - timer mode counts down on clk_div_1, clk_div_8, clk_div_32 or subclk_div_32
// - on underflow the counter reloads from the reload register and keeps counting
// - a set value n gives one underflow per n+1 counted events
// - counting happens only while the start flag is 1
// - every underflow raises the interrupt request
// - event mode counts pin edges or another timer's overflow
// - event pin edge is rising, falling or both, chosen by software
// - pin is a count input in event mode, a plain port in timer mode
// - in down-count modes a timer read returns the live count
// - a timer write while stopped loads reload register and counter
// - a timer write while running loads only the reload register
// - measurement mode counts up on the chosen internal clock
// - each effective edge captures the count, clears the counter, counting goes on
// - each effective edge interrupts except the first one after start
// - up-count overflow interrupts and sets the overflow flag at once
// - a mode register write while started clears the overflow flag
// - in measurement mode a timer read returns the captured value
// - in measurement mode timer writes change nothing
module gtimer
    import gtimer_pkg::*;
#(
    parameter int CNT_W = CNT_WIDTH,
    parameter int ADDR_W = 8
)
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // count sources and measured pin
    input wire logic subclk_div_32,
    input wire logic other_timer_ovf,
    input wire logic timer_event_input_pin,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // block outputs
    output logic irq,
    output logic pin_is_count_input
);

    // ****************************************
    // helpers
    // ****************************************

    // byte-lane merge of write data into an old word
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // true when an address hits a register offset
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction

    // ****************************************
    // state
    // ****************************************
    mode_reg_t mode_q;
    logic start_q;
    logic ovf_q;
    logic first_q;
    logic pin_prev_q;
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] reload_q;
    logic irq_q;
    logic pin_in_q;
    logic awready_q;
    logic wready_q;
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // ****************************************
    // decode and count events
    // ****************************************
    logic wr_fire;
    logic mode_wr;
    logic start_wr;
    logic timer_wr;
    logic [31:0] mode_word;
    logic [31:0] mode_new;
    logic [31:0] start_new;
    logic [CNT_W-1:0] timer_new;
    logic is_meas;
    logic is_down;
    logic clk_tick;
    logic pin_rise;
    logic pin_fall;
    logic pin_edge;
    logic cnt_tick;
    logic underflow;
    logic meas_edge;
    logic overflow;

    // write strobes and merged write values
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign mode_wr = wr_fire && addr_hit(waddr_q, OFS_MODE);
    assign start_wr = wr_fire && addr_hit(waddr_q, OFS_START);
    assign timer_wr = wr_fire && addr_hit(waddr_q, OFS_TIMER);
    assign mode_word = {24'h000000, mode_q.clk_sel, ovf_q, mode_q.ev_src, mode_q.edge_sel,
                        mode_q.mode};
    assign mode_new = strb_merge(mode_word, wdata_q, wstrb_q);
    assign start_new = strb_merge({31'h00000000, start_q}, wdata_q, wstrb_q);
    assign timer_new = CNT_W'(strb_merge(32'(cnt_q), wdata_q, wstrb_q));

    // mode decode
    assign is_meas = mode_q.mode == MODE_MEAS;
    assign is_down = mode_q.mode == MODE_TIMER || mode_q.mode == MODE_EVENT;

    // internal clock tick from the prescaler or the divided subclock
    always_comb
    begin
        case (mode_q.clk_sel)
            CLK_SEL_DIV1: clk_tick = 1'b1;
            CLK_SEL_DIV8: clk_tick = pre_q[2:0] == DIV8_LAST;
            CLK_SEL_DIV32: clk_tick = pre_q == DIV32_LAST;
            default: clk_tick = subclk_div_32;
        endcase
    end

    // pin edges and selected edge
    assign pin_rise = timer_event_input_pin && !pin_prev_q;
    assign pin_fall = !timer_event_input_pin && pin_prev_q;
    always_comb
    begin
        case (mode_q.edge_sel)
            EDGE_FALL: pin_edge = pin_fall;
            EDGE_RISE: pin_edge = pin_rise;
            EDGE_BOTH: pin_edge = pin_rise || pin_fall;
            default: pin_edge = 1'b0;
        endcase
    end

    // count event of the down-count modes
    assign cnt_tick = (mode_q.mode == MODE_EVENT)
                      ? (mode_q.ev_src ? other_timer_ovf : pin_edge)
                      : clk_tick;
    assign underflow = is_down && start_q && cnt_tick && cnt_q == '0;
    assign meas_edge = is_meas && start_q && pin_edge;
    assign overflow = is_meas && start_q && !pin_edge && clk_tick && (&cnt_q);

    // ****************************************
    // prescaler and pin history
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pre_q <= '0;
            pin_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            pre_q <= pre_q + 1'b1;
            pin_prev_q <= timer_event_input_pin;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q.mode <= MODE_RST;
            mode_q.edge_sel <= EDGE_RST;
            mode_q.ev_src <= 1'b0;
            mode_q.clk_sel <= CLK_RST;
            start_q <= START_RST;
        end
        else if (ce)
        begin
            if (mode_wr)
            begin
                mode_q.mode <= mode_new[F_MODE_LSB +: 2];
                mode_q.edge_sel <= mode_new[F_EDGE_LSB +: 2];
                mode_q.ev_src <= mode_new[F_SRC_BIT];
                mode_q.clk_sel <= mode_new[F_CLK_LSB +: 2];
            end
            if (start_wr)
            begin
                start_q <= start_new[F_START_BIT];
            end
        end
    end

    // overflow flag: a new overflow wins over the clearing write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ovf_q <= 1'b0;
        end
        else if (ce)
        begin
            if (overflow)
            begin
                ovf_q <= 1'b1;
            end
            else if (mode_wr && start_q)
            begin
                ovf_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // counter and reload register
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= CNT_W'(CNT_RST);
            reload_q <= CNT_W'(CNT_RST);
            first_q <= 1'b0;
        end
        else if (ce)
        begin
            if (is_meas)
            begin
                // writes are ignored here
                if (!start_q)
                begin
                    first_q <= 1'b0;
                end
                else if (pin_edge)
                begin
                    reload_q <= cnt_q;
                    cnt_q <= '0;
                    first_q <= 1'b1;
                end
                else if (clk_tick)
                begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
            else
            begin
                first_q <= 1'b0;
                if (timer_wr)
                begin
                    reload_q <= timer_new;
                end
                if (timer_wr && !start_q)
                begin
                    cnt_q <= timer_new;
                end
                else if (underflow)
                begin
                    cnt_q <= reload_q;
                end
                else if (is_down && start_q && cnt_tick)
                begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    // ****************************************
    // interrupt pulse and pin role
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_q <= 1'b0;
            pin_in_q <= 1'b0;
        end
        else if (ce)
        begin
            irq_q <= underflow || (meas_edge && first_q) || overflow;
            pin_in_q <= mode_q.mode == MODE_EVENT || is_meas;
        end
    end

    // ****************************************
    // bus write side
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && awready_q)
            begin
                waddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (mode_wr || start_wr || timer_wr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // bus read side
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && arready_q)
            begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= RESP_OKAY;
                if (addr_hit(s_axi_araddr, OFS_MODE))
                begin
                    rdata_q <= mode_word;
                end
                else if (addr_hit(s_axi_araddr, OFS_START))
                begin
                    rdata_q <= {31'h00000000, start_q};
                end
                else if (addr_hit(s_axi_araddr, OFS_TIMER))
                begin
                    rdata_q <= 32'(is_meas ? reload_q : cnt_q);
                end
                else
                begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= RESP_SLVERR;
                end
            end
            if (rvalid_q && s_axi_rready)
            begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // output drive
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;
    assign pin_is_count_input = pin_in_q;

    // ****************************************
    // checks
    // ****************************************
    AST_RELOAD_ON_UNDERFLOW: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && underflow && !timer_wr |=> cnt_q == $past(reload_q))
        else $error("counter did not reload on underflow");

    AST_IRQ_ON_UNDERFLOW: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && underflow |=> irq_q)
        else $error("no interrupt on underflow");

    AST_DECREMENT: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && is_down && start_q && cnt_tick && cnt_q != '0 && !timer_wr
        |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("counter did not step down by one");

    AST_STOPPED_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !start_q && !timer_wr |=> $stable(cnt_q) && !irq_q)
        else $error("counter moved while stopped");

    AST_WRITE_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && timer_wr && !start_q && is_down
        |=> cnt_q == $past(timer_new) && reload_q == $past(timer_new))
        else $error("stopped write did not load both registers");

    AST_WRITE_RUNNING: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && timer_wr && start_q && is_down && !underflow
        |=> reload_q == $past(timer_new) && cnt_q == $past(cnt_q) - $past(cnt_tick))
        else $error("running write touched the counter");

    AST_MEAS_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && meas_edge |=> cnt_q == '0 && reload_q == $past(cnt_q))
        else $error("edge did not capture and clear");

    AST_FIRST_EDGE_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && meas_edge && !first_q |=> !irq_q ##0 first_q)
        else $error("first edge raised an interrupt");

    AST_OVF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && overflow |=> ovf_q && irq_q && cnt_q == '0)
        else $error("overflow did not set flag and interrupt together");

    AST_MEAS_NO_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && is_meas && timer_wr && !start_q |=> $stable(reload_q) && $stable(cnt_q))
        else $error("write changed registers in measurement mode");

endmodule

// [gtimer_pkg.sv]
// package with register map, field layout and mode codes of the general timer
package gtimer_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_TIMER = 8'h08;

    // ****************************************
    // mode register field positions
    // ****************************************
    localparam int F_MODE_LSB = 0;
    localparam int F_EDGE_LSB = 2;
    localparam int F_SRC_BIT = 4;
    localparam int F_OVF_BIT = 5;
    localparam int F_CLK_LSB = 6;
    localparam int F_START_BIT = 0;

    // ****************************************
    // reset values and widths
    // ****************************************
    localparam int CNT_WIDTH = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] EDGE_RST = 2'h0;
    localparam logic [1:0] CLK_RST = 2'h0;
    localparam logic START_RST = 1'b0;
    localparam int PRE_W = 5;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [4:0] DIV32_LAST = 5'h1F;

    // ****************************************
    // bus response codes
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_MEAS = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] CLK_SEL_DIV1 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV8 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV32 = 2'h2;

    // stored part of the mode register
    typedef struct packed {
        logic [1:0] clk_sel;
        logic ev_src;
        logic [1:0] edge_sel;
        logic [1:0] mode;
    } mode_reg_t;

endpackage

// [pulse_source.sv]
// partner model: pin pulse train, other-timer overflow and subclock tick
`timescale 1ns/100ps

module pulse_source
#(
    parameter int SUB_P = 4,
    parameter int OVF_P = 6
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control from the bench
    input wire logic run,
    input wire logic [15:0] half,
    // event outputs
    output logic timer_event_input_pin,
    output logic other_timer_ovf,
    output logic subclk_div_32
);
    // ********
    // sources
    // ********
    int ph_q;
    int tk_q;

    // pin toggles every half cycles while run is high, stands still otherwise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_q <= 0;
            timer_event_input_pin <= 1'b0;
        end
        else if (!run)
            ph_q <= 0;
        else if (ph_q == int'(half) - 1)
        begin
            ph_q <= 0;
            timer_event_input_pin <= ~timer_event_input_pin;
        end
        else
            ph_q <= ph_q + 1;
    end

    // free-running one-cycle pulses for the internal event sources
    always_ff @(posedge aclk)
    begin
        tk_q <= aresetn ? tk_q + 1 : 0;
        subclk_div_32 <= aresetn && (tk_q % SUB_P == 0);
        other_timer_ovf <= aresetn && (tk_q % OVF_P == 0);
    end
endmodule
